/* rtl/dpc_cfg_if.sv */
`timescale 1ns/1ps
interface dpc_cfg_if;
	logic fast_acquire_enable;
	logic [dpc_pkg::WINDOW_W-1:0] phase_window_size;
	logic [1:0] oscillator_error_gain;
	logic phase_locked;
	logic acquiring;

	modport ctrl (output fast_acquire_enable, output phase_window_size, output oscillator_error_gain,
		input phase_locked, input acquiring);
	modport sel (input fast_acquire_enable, input phase_window_size, output phase_locked, output acquiring);
	modport scale (input oscillator_error_gain);
endinterface

/* rtl/dpc_error_scale.sv */
`timescale 1ns/1ps
module dpc_error_scale
(
	input wire logic clk,
	input wire logic sys_rst,
	dpc_cfg_if.scale cfg,
	input wire logic signed [dpc_pkg::ERR_W-1:0] freq_error,
	output logic signed [dpc_pkg::ERR_W-1:0] scaled_error
);
	localparam logic signed [dpc_pkg::ERR_W+1:0] MAX_VAL = 26'sh07FFFFF;
	localparam logic signed [dpc_pkg::ERR_W+1:0] MIN_VAL = -26'sh0800000;
	logic signed [dpc_pkg::ERR_W+1:0] wide;
	logic signed [dpc_pkg::ERR_W+1:0] next_wide;

	assign wide = {{2{freq_error[dpc_pkg::ERR_W-1]}}, freq_error};

	always_comb
	begin
		case (cfg.oscillator_error_gain)
			dpc_pkg::GAIN_HALF: next_wide = wide >>> 1; // [R11]
			dpc_pkg::GAIN_ONE: next_wide = wide;
			dpc_pkg::GAIN_TWO: next_wide = wide <<< 1;
			default: next_wide = wide <<< 2;
		endcase
	end

	// Saturate rather than wrap, so a large error never flips the DCO sign
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			scaled_error <= '0;
		else if (next_wide > MAX_VAL)
			scaled_error <= MAX_VAL[dpc_pkg::ERR_W-1:0];
		else if (next_wide < MIN_VAL)
			scaled_error <= MIN_VAL[dpc_pkg::ERR_W-1:0];
		else
			scaled_error <= next_wide[dpc_pkg::ERR_W-1:0];
	end
endmodule

/* rtl/dpc_loop_config.sv */
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Averaging enable off means no holdover averaging
// [R2] Mode 00 instant history, 01 fast average
// [R3] Fast acquire off: always locked bandwidth, damping
// [R4] Fast acquire on: acquisition settings until locked
// [R5] Lock window counts 2.5ns steps, 640ns span
// [R6] Software never writes zero lock window
// [R7] Software keeps integer part at most FFh
// [R8] Below 16MHz crystal, software enables doubler
// [R9] Fraction equals field over two to 21
// [R10] Order 00 off, then first to third
// [R11] Error gain 0.5, 1, 2, 4
// [R12] Dither none, one, two, four LSBs
// [R13] Reserved encodings are software's to avoid
module dpc_loop_config
#(
	parameter int HIST_CYCLES = dpc_pkg::HIST_CYCLES
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	input wire logic [dpc_pkg::WINDOW_W-1:0] phase_error_mag,
	input wire logic signed [dpc_pkg::ERR_W-1:0] freq_error,
	input wire logic signed [dpc_pkg::ERR_W-1:0] dco_word,
	input wire logic holdover_active,
	input wire logic [dpc_pkg::SET_W-1:0] acquisition_bandwidth_setting,
	input wire logic [dpc_pkg::SET_W-1:0] acquisition_damping_setting,
	input wire logic [dpc_pkg::SET_W-1:0] locked_bandwidth_setting,
	input wire logic [dpc_pkg::SET_W-1:0] locked_damping_setting,
	output logic [dpc_pkg::SET_W-1:0] selected_bandwidth,
	output logic [dpc_pkg::SET_W-1:0] selected_damping,
	output logic phase_locked,
	output logic signed [dpc_pkg::ERR_W-1:0] scaled_error,
	output logic signed [dpc_pkg::ERR_W-1:0] holdover_word,
	output logic [dpc_pkg::INT_W+dpc_pkg::FRAC_W-1:0] feedback_value,
	output logic modulator_enable,
	output logic [1:0] modulator_order,
	output logic [dpc_pkg::DITHER_W-1:0] dither_word
);
	logic [1:0] holdover_mode_select;
	logic holdover_averaging_enable;
	logic fast_acquire_enable;
	logic [dpc_pkg::WINDOW_W-1:0] phase_window_size;
	logic [dpc_pkg::INT_W-1:0] feedback_integer_part;
	logic [dpc_pkg::FRAC_W-1:0] feedback_fraction_part;
	logic [1:0] modulator_order_select;
	logic [1:0] oscillator_error_gain;
	logic [2:0] dither_amount;
	logic [7:0] next_rdata;
	logic [31:0] hist_count;
	logic hist_tick;
	logic signed [dpc_pkg::ERR_W-1:0] hist_recent;
	logic signed [dpc_pkg::ERR_W-1:0] hist_old;
	logic signed [dpc_pkg::ERR_W-1:0] avg_word;
	logic signed [dpc_pkg::ERR_W:0] avg_diff;
	logic signed [dpc_pkg::ERR_W:0] avg_step;
	logic holdover_prev;
	logic holdover_entry;
	logic [dpc_pkg::LFSR_W-1:0] lfsr;

	dpc_cfg_if cfg_bus();

	assign cfg_bus.fast_acquire_enable = fast_acquire_enable;
	assign cfg_bus.phase_window_size = phase_window_size;
	assign cfg_bus.oscillator_error_gain = oscillator_error_gain;

	dpc_loop_select u_select
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.cfg(cfg_bus.sel),
		.phase_error_mag(phase_error_mag),
		.acquisition_bandwidth_setting(acquisition_bandwidth_setting),
		.acquisition_damping_setting(acquisition_damping_setting),
		.locked_bandwidth_setting(locked_bandwidth_setting),
		.locked_damping_setting(locked_damping_setting),
		.selected_bandwidth(selected_bandwidth),
		.selected_damping(selected_damping)
	);

	dpc_error_scale u_scale
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.cfg(cfg_bus.scale),
		.freq_error(freq_error),
		.scaled_error(scaled_error)
	);

	assign phase_locked = cfg_bus.phase_locked;

	// Dither mask: only the documented codes dither at all
	function automatic logic [dpc_pkg::DITHER_W-1:0] dither_mask(input logic [2:0] amount);
		logic [dpc_pkg::DITHER_W-1:0] mask;
		mask = 4'h0;
		case (amount)
			dpc_pkg::DITHER_ONE: mask = 4'h1;
			dpc_pkg::DITHER_TWO: mask = 4'h3;
			dpc_pkg::DITHER_FOUR: mask = 4'hF;
			default: mask = 4'h0;
		endcase
		return mask;
	endfunction

	// Mode and enable fields
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			holdover_mode_select <= dpc_pkg::HOLD_MODE_RST;
			holdover_averaging_enable <= dpc_pkg::HOLD_AVG_RST;
			fast_acquire_enable <= dpc_pkg::FAST_ACQ_RST;
		end
		else if (reg_wr && reg_addr == dpc_pkg::ADDR_MODE)
		begin
			holdover_mode_select <= reg_wdata[dpc_pkg::HOLD_MODE_LSB +: 2];
			holdover_averaging_enable <= reg_wdata[dpc_pkg::HOLD_AVG_BIT];
			fast_acquire_enable <= reg_wdata[dpc_pkg::FAST_ACQ_BIT];
		end
	end

	// Lock window; zero is stored as written since software must avoid it
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			phase_window_size <= dpc_pkg::WINDOW_RST;
		else if (reg_wr && reg_addr == dpc_pkg::ADDR_WINDOW)
			phase_window_size <= reg_wdata; // [R5]
	end

	// Feedback integer and fraction, written a byte at a time
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			feedback_integer_part <= dpc_pkg::INT_RST;
			feedback_fraction_part <= dpc_pkg::FRAC_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == dpc_pkg::ADDR_INT_LO)
				feedback_integer_part[7:0] <= reg_wdata;
			else if (reg_addr == dpc_pkg::ADDR_INT_HI)
				feedback_integer_part[8] <= reg_wdata[0];
			else if (reg_addr == dpc_pkg::ADDR_FRAC_0)
				feedback_fraction_part[7:0] <= reg_wdata;
			else if (reg_addr == dpc_pkg::ADDR_FRAC_1)
				feedback_fraction_part[15:8] <= reg_wdata;
			else if (reg_addr == dpc_pkg::ADDR_FRAC_2)
				feedback_fraction_part[20:16] <= reg_wdata[4:0];
		end
	end

	// Modulator order, error gain and dither fields
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			modulator_order_select <= dpc_pkg::ORDER_RST; // [R10]
			oscillator_error_gain <= dpc_pkg::GAIN_RST;
			dither_amount <= dpc_pkg::DITHER_RST;
		end
		else if (reg_wr && reg_addr == dpc_pkg::ADDR_MOD)
		begin
			modulator_order_select <= reg_wdata[dpc_pkg::ORDER_LSB +: 2];
			oscillator_error_gain <= reg_wdata[dpc_pkg::GAIN_LSB +: 2];
			dither_amount <= reg_wdata[dpc_pkg::DITHER_LSB +: 3];
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (reg_addr == dpc_pkg::ADDR_MODE)
		begin
			next_rdata[dpc_pkg::HOLD_MODE_LSB +: 2] = holdover_mode_select;
			next_rdata[dpc_pkg::HOLD_AVG_BIT] = holdover_averaging_enable;
			next_rdata[dpc_pkg::FAST_ACQ_BIT] = fast_acquire_enable;
		end
		else if (reg_addr == dpc_pkg::ADDR_WINDOW)
			next_rdata = phase_window_size;
		else if (reg_addr == dpc_pkg::ADDR_INT_LO)
			next_rdata = feedback_integer_part[7:0];
		else if (reg_addr == dpc_pkg::ADDR_INT_HI)
			next_rdata[0] = feedback_integer_part[8];
		else if (reg_addr == dpc_pkg::ADDR_FRAC_0)
			next_rdata = feedback_fraction_part[7:0];
		else if (reg_addr == dpc_pkg::ADDR_FRAC_1)
			next_rdata = feedback_fraction_part[15:8];
		else if (reg_addr == dpc_pkg::ADDR_FRAC_2)
			next_rdata[4:0] = feedback_fraction_part[20:16];
		else if (reg_addr == dpc_pkg::ADDR_MOD)
		begin
			next_rdata[dpc_pkg::ORDER_LSB +: 2] = modulator_order_select;
			next_rdata[dpc_pkg::GAIN_LSB +: 2] = oscillator_error_gain;
			next_rdata[dpc_pkg::DITHER_LSB +: 3] = dither_amount;
		end
		else if (reg_addr == dpc_pkg::ADDR_STATUS)
		begin
			next_rdata[dpc_pkg::STAT_LOCKED_BIT] = cfg_bus.phase_locked;
			next_rdata[dpc_pkg::STAT_HOLD_BIT] = holdover_active;
			next_rdata[dpc_pkg::STAT_ACQ_BIT] = cfg_bus.acquiring;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

	// Feedback value as 9.21 fixed point, fraction over two to the 21
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			feedback_value <= {dpc_pkg::INT_RST, dpc_pkg::FRAC_RST};
			modulator_enable <= 1'b1;
			modulator_order <= dpc_pkg::ORDER_RST;
		end
		else
		begin
			feedback_value <= {feedback_integer_part, feedback_fraction_part}; // [R9] [R7]
			modulator_enable <= (modulator_order_select != dpc_pkg::ORDER_OFF); // [R10]
			modulator_order <= modulator_order_select;
		end
	end

	// History tick every 100ms
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			hist_count <= 32'h0;
		else if (hist_count >= 32'(HIST_CYCLES - 1))
			hist_count <= 32'h0;
		else
			hist_count <= hist_count + 32'h1;
	end

	assign hist_tick = (hist_count >= 32'(HIST_CYCLES - 1));

	// Two snapshots, so the older one is always at least 100ms old at holdover entry
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hist_recent <= '0;
			hist_old <= '0;
		end
		else if (hist_tick && !holdover_active)
		begin
			hist_recent <= dco_word;
			hist_old <= hist_recent; // [R2]
		end
	end

	// Fast running average of the DCO word, frozen during holdover
	assign avg_diff = {dco_word[dpc_pkg::ERR_W-1], dco_word} - {avg_word[dpc_pkg::ERR_W-1], avg_word};
	assign avg_step = avg_diff >>> dpc_pkg::AVG_SHIFT;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			avg_word <= '0;
		else if (!holdover_active)
			avg_word <= avg_word + avg_step[dpc_pkg::ERR_W-1:0];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			holdover_prev <= 1'b0;
		else
			holdover_prev <= holdover_active;
	end

	assign holdover_entry = holdover_active && !holdover_prev;

	// Holdover value chosen on entry; reserved modes fall back to the live word
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			holdover_word <= '0;
		else if (holdover_entry)
		begin
			if (!holdover_averaging_enable)
				holdover_word <= dco_word; // [R1]
			else if (holdover_mode_select == dpc_pkg::HOLD_INSTANT)
				holdover_word <= hist_old; // [R2]
			else if (holdover_mode_select == dpc_pkg::HOLD_FAST_AVG)
				holdover_word <= avg_word; // [R2]
			else
				holdover_word <= dco_word;
		end
		else if (!holdover_active)
			holdover_word <= dco_word;
	end

	// Dither source
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			lfsr <= dpc_pkg::LFSR_SEED;
		else if (lfsr[0])
			lfsr <= (lfsr >> 1) ^ dpc_pkg::LFSR_TAPS;
		else
			lfsr <= lfsr >> 1;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			dither_word <= '0;
		else
			dither_word <= lfsr[dpc_pkg::DITHER_W-1:0] & dither_mask(dither_amount); // [R12]
	end
endmodule

/* rtl/dpc_loop_select.sv */
`timescale 1ns/1ps
module dpc_loop_select
(
	input wire logic clk,
	input wire logic sys_rst,
	dpc_cfg_if.sel cfg,
	input wire logic [dpc_pkg::WINDOW_W-1:0] phase_error_mag,
	input wire logic [dpc_pkg::SET_W-1:0] acquisition_bandwidth_setting,
	input wire logic [dpc_pkg::SET_W-1:0] acquisition_damping_setting,
	input wire logic [dpc_pkg::SET_W-1:0] locked_bandwidth_setting,
	input wire logic [dpc_pkg::SET_W-1:0] locked_damping_setting,
	output logic [dpc_pkg::SET_W-1:0] selected_bandwidth,
	output logic [dpc_pkg::SET_W-1:0] selected_damping
);
	logic locked;
	logic use_acq;

	// Error and window share the 2.5ns step; a zero window can never judge lock
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			locked <= 1'b0;
		else
			locked <= (phase_error_mag < cfg.phase_window_size); // [R5]
	end

	assign use_acq = cfg.fast_acquire_enable && !locked; // [R3] [R4]

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			selected_bandwidth <= '0;
			selected_damping <= '0;
		end
		else if (use_acq)
		begin
			selected_bandwidth <= acquisition_bandwidth_setting; // [R4]
			selected_damping <= acquisition_damping_setting;
		end
		else
		begin
			selected_bandwidth <= locked_bandwidth_setting; // [R3]
			selected_damping <= locked_damping_setting;
		end
	end

	assign cfg.phase_locked = locked;
	assign cfg.acquiring = use_acq;
endmodule

/* rtl/dpc_pkg.sv */
package dpc_pkg;
	// Register offsets on the byte-wide host register port
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_WINDOW = 8'h01;
	localparam logic [7:0] ADDR_INT_LO = 8'h02;
	localparam logic [7:0] ADDR_INT_HI = 8'h03;
	localparam logic [7:0] ADDR_FRAC_0 = 8'h04;
	localparam logic [7:0] ADDR_FRAC_1 = 8'h05;
	localparam logic [7:0] ADDR_FRAC_2 = 8'h06;
	localparam logic [7:0] ADDR_MOD = 8'h07;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// Field positions in the mode register
	localparam int HOLD_MODE_LSB = 0;
	localparam int HOLD_AVG_BIT = 2;
	localparam int FAST_ACQ_BIT = 3;
	// Field positions in the modulator register
	localparam int ORDER_LSB = 0;
	localparam int GAIN_LSB = 2;
	localparam int DITHER_LSB = 4;
	// Field positions in the status register
	localparam int STAT_LOCKED_BIT = 0;
	localparam int STAT_HOLD_BIT = 1;
	localparam int STAT_ACQ_BIT = 2;

	// Field widths
	localparam int WINDOW_W = 8;
	localparam int INT_W = 9;
	localparam int FRAC_W = 21;
	localparam int SET_W = 4;
	localparam int ERR_W = 24;
	localparam int DITHER_W = 4;
	localparam int LFSR_W = 16;

	// Reset values and LFSR taps
	localparam logic [1:0] HOLD_MODE_RST = 2'h0;
	localparam logic HOLD_AVG_RST = 1'b0;
	localparam logic FAST_ACQ_RST = 1'b0;
	localparam logic [WINDOW_W-1:0] WINDOW_RST = 8'h3F;
	localparam logic [INT_W-1:0] INT_RST = 9'h02D;
	localparam logic [FRAC_W-1:0] FRAC_RST = 21'h000000;
	localparam logic [1:0] ORDER_RST = 2'h3;
	localparam logic [1:0] GAIN_RST = 2'h1;
	localparam logic [2:0] DITHER_RST = 3'h0;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
	localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;

	// Encodings
	localparam logic [1:0] HOLD_INSTANT = 2'h0;
	localparam logic [1:0] HOLD_FAST_AVG = 2'h1;
	localparam logic [1:0] ORDER_OFF = 2'h0;
	localparam logic [1:0] GAIN_HALF = 2'h0;
	localparam logic [1:0] GAIN_ONE = 2'h1;
	localparam logic [1:0] GAIN_TWO = 2'h2;
	localparam logic [2:0] DITHER_NONE = 3'h0;
	localparam logic [2:0] DITHER_ONE = 3'h1;
	localparam logic [2:0] DITHER_TWO = 3'h2;
	localparam logic [2:0] DITHER_FOUR = 3'h3;

	// Timing: history age and averaging constant
	localparam int CLK_MHZ = 200;
	localparam int HIST_AGE_MS = 100;
	localparam int HIST_CYCLES = HIST_AGE_MS * CLK_MHZ * 1000;
	localparam int AVG_SHIFT = 4;
	// Lock window step and span, in picoseconds
	localparam int WINDOW_STEP_PS = 2500;
	localparam int WINDOW_SPAN_PS = 640000;
endpackage

/* tb/dpc_loop_config_props.sv */
`timescale 1ns/1ps
module dpc_loop_config_props
#(
	parameter int HIST_CYCLES = 16
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [7:0] phase_error_mag,
	input wire logic signed [23:0] freq_error,
	input wire logic signed [23:0] dco_word,
	input wire logic holdover_active,
	input wire logic [3:0] acquisition_bandwidth_setting,
	input wire logic [3:0] locked_bandwidth_setting,
	input wire logic [3:0] selected_bandwidth,
	input wire logic phase_locked,
	input wire logic signed [23:0] scaled_error,
	input wire logic signed [23:0] holdover_word,
	input wire logic [29:0] feedback_value,
	input wire logic modulator_enable,
	input wire logic [1:0] modulator_order,
	input wire logic [3:0] dither_word
);
	// Shadow of the writable bytes, so field values are known from the port alone
	logic [7:0] sh [8];
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sh <= '{8'h00, 8'h3F, 8'h2D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};
		else if (reg_wr && reg_addr < 8'h08)
			sh[reg_addr[2:0]] <= reg_wdata;
	end
	function automatic logic signed [23:0] scale(input logic signed [23:0] x, input logic [1:0] g);
		logic signed [26:0] w;
		w = x;
		w = (g == 2'h0) ? (w >>> 1) : (w <<< (g - 2'h1));
		if (w > 27'sh07FFFFF)
			return 24'h7FFFFF;
		if (w < -27'sh0800000)
			return 24'h800000;
		return w[23:0];
	endfunction
	function automatic logic [3:0] dmask(input logic [2:0] d);
		return (d == 3'h1) ? 4'h1 : (d == 3'h2) ? 4'h3 : (d == 3'h3) ? 4'hF : 4'h0;
	endfunction
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_LOCK_STRICT: assert property (!$past(sys_rst)
		|-> phase_locked == ($past(phase_error_mag) < $past(sh[1])))
		else $error("phase_locked wrong");
	AST_NORMAL_SET: assert property (!$past(sys_rst) && (!$past(sh[0][3]) || $past(phase_locked))
		|-> selected_bandwidth == $past(locked_bandwidth_setting))
		else $error("locked settings not used");
	AST_ACQ_SET: assert property (!$past(sys_rst) && $past(sh[0][3]) && !$past(phase_locked)
		|-> selected_bandwidth == $past(acquisition_bandwidth_setting))
		else $error("acquisition settings not used");
	AST_ORDER: assert property (!$past(sys_rst) |-> modulator_order == $past(sh[7][1:0])
		&& modulator_enable == ($past(sh[7][1:0]) != 2'h0))
		else $error("modulator order wrong");
	AST_FEEDBACK: assert property (!$past(sys_rst)
		|-> feedback_value == $past({sh[3][0], sh[2], sh[6][4:0], sh[5], sh[4]}))
		else $error("feedback value wrong");
	AST_GAIN: assert property (!$past(sys_rst)
		|-> scaled_error == scale($past(freq_error), $past(sh[7][3:2])))
		else $error("scaled error wrong");
	AST_DITHER: assert property (!$past(sys_rst) |-> (dither_word & ~dmask($past(sh[7][6:4]))) == 4'h0)
		else $error("dither outside mask");
	AST_HOLD_TRACK: assert property (!$past(sys_rst) && !$past(holdover_active)
		|-> holdover_word == $past(dco_word))
		else $error("holdover word not tracking");
	AST_HOLD_OFF: assert property (!$past(sys_rst) && $past(holdover_active) && !$past(holdover_active, 2)
		&& !$past(sh[0][2]) |-> holdover_word == $past(dco_word))
		else $error("holdover entry without averaging wrong");
	AST_HOLD_FREEZE: assert property (!$past(sys_rst) && $past(holdover_active) && $past(holdover_active, 2)
		|-> $stable(holdover_word))
		else $error("holdover word moved");
	cover property (phase_locked && sh[0][3]);
	cover property ($rose(holdover_active));
	cover property ($rose(holdover_active) && sh[0][2] && sh[0][1:0] == 2'h1);
	cover property (scaled_error == 24'h7FFFFF);
endmodule
bind dpc_loop_config dpc_loop_config_props #(.HIST_CYCLES(HIST_CYCLES)) dpc_loop_config_props_i (.clk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .phase_error_mag, .freq_error, .dco_word, .holdover_active,
	.acquisition_bandwidth_setting, .locked_bandwidth_setting, .selected_bandwidth, .phase_locked,
	.scaled_error, .holdover_word, .feedback_value, .modulator_enable, .modulator_order, .dither_word);

/* tb/dpc_loop_config_test.sv */
`timescale 1ns/1ps
module dpc_loop_config_test;
	logic clk, sys_rst, reg_wr, holdover_active, phase_locked, modulator_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, phase_error_mag;
	logic signed [23:0] freq_error, dco_word, scaled_error, holdover_word;
	logic [3:0] acquisition_bandwidth_setting, acquisition_damping_setting;
	logic [3:0] locked_bandwidth_setting, locked_damping_setting;
	logic [3:0] selected_bandwidth, selected_damping, dither_word, acc, m;
	logic [29:0] feedback_value;
	logic [1:0] modulator_order;
	logic [23:0] ex;
	int error_cnt, cmp_count;
	localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'h3F, 8'h2D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};
	// Short history so the instant holdover snapshot is reachable in a short run
	dpc_loop_config #(.HIST_CYCLES(16)) dpc_loop_config_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rdata, .phase_error_mag, .freq_error, .dco_word, .holdover_active, .acquisition_bandwidth_setting,
		.acquisition_damping_setting, .locked_bandwidth_setting, .locked_damping_setting, .selected_bandwidth,
		.selected_damping, .phase_locked, .scaled_error, .holdover_word, .feedback_value, .modulator_enable,
		.modulator_order, .dither_word);
	always #2.5 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		clk = 1'b0;
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		phase_error_mag = 8'hFF;
		freq_error = 24'h000000;
		dco_word = 24'h000000;
		holdover_active = 1'b0;
		acquisition_bandwidth_setting = 4'hA;
		acquisition_damping_setting = 4'hB;
		locked_bandwidth_setting = 4'h3;
		locked_damping_setting = 4'h4;
		cyc(2);
		sys_rst = 1'b0;
		chk("feedback_value", {2'h0, 9'h02D, 21'h0}, {2'h0, feedback_value});
		chk("modulator_order", 32'h3, {30'h0, modulator_order});
		for (int a = 0; a < 8; a++)
			rd(8'(a), RST_TAB[a]);
		wr(8'h09, 8'h55);
		rd(8'h09, 8'h00);
		wr(8'h01, 8'h10);
		phase_error_mag = 8'h0F;
		cyc(2);
		chk("phase_locked", 32'h1, {31'h0, phase_locked});
		phase_error_mag = 8'h10;
		cyc(3);
		chk("phase_locked", 32'h0, {31'h0, phase_locked});
		chk("selected_bandwidth", 32'h3, {28'h0, selected_bandwidth});
		wr(8'h00, 8'h08);
		cyc(2);
		chk("selected_damping", 32'hB, {28'h0, selected_damping});
		rd(8'h08, 8'h04);
		phase_error_mag = 8'h0F;
		cyc(3);
		chk("selected_damping", 32'h4, {28'h0, selected_damping});
		rd(8'h00, 8'h08);
		rd(8'h08, 8'h01);
		for (int o = 0; o < 4; o++)
		begin
			wr(8'h07, 8'(o));
			cyc(1);
			chk("modulator_enable", {31'h0, o != 0}, {31'h0, modulator_enable});
			chk("modulator_order", 32'(o), {30'h0, modulator_order});
			rd(8'h07, 8'(o));
		end
		freq_error = 24'h000100;
		for (int g = 0; g < 4; g++)
		begin
			wr(8'h07, {4'h0, 2'(g), 2'h3});
			cyc(1);
			ex = (g == 0) ? 24'h000080 : (24'h000100 << (g - 1));
			chk("scaled_error", {8'h0, ex}, {8'h0, scaled_error});
		end
		freq_error = 24'h300000;
		cyc(2);
		chk("scaled_error", 32'h7FFFFF, {8'h0, scaled_error});
		freq_error = 24'hD00000;
		cyc(2);
		chk("scaled_error", 32'h800000, {8'h0, scaled_error});
		// Only the defined dither codes are written; the others are left to software to avoid
		for (int d = 0; d < 4; d++)
		begin
			m = (d == 1) ? 4'h1 : (d == 2) ? 4'h3 : (d == 3) ? 4'hF : 4'h0;
			wr(8'h07, {1'b0, 3'(d), 4'h3});
			acc = 4'h0;
			repeat (32)
			begin
				@(negedge clk);
				acc = acc | dither_word;
			end
			chk("dither_word", {28'h0, m}, {28'h0, acc});
		end
		wr(8'h02, 8'hFF);
		wr(8'h04, 8'hFF);
		wr(8'h05, 8'hFF);
		wr(8'h06, 8'h1F);
		cyc(1);
		chk("feedback_value", {2'h0, 9'h0FF, 21'h1FFFFF}, {2'h0, feedback_value});
		rd(8'h06, 8'h1F);
		wr(8'h00, 8'h00);
		dco_word = 24'h000123;
		cyc(3);
		holdover_active = 1'b1;
		cyc(2);
		dco_word = 24'h000456;
		cyc(3);
		chk("holdover_word", 32'h123, {8'h0, holdover_word});
		holdover_active = 1'b0;
		cyc(2);
		chk("holdover_word", 32'h456, {8'h0, holdover_word});
		wr(8'h00, 8'h04);
		dco_word = 24'h00AAAA;
		cyc(70);
		dco_word = 24'h00BBBB;
		cyc(3);
		holdover_active = 1'b1;
		cyc(3);
		chk("holdover_word", 32'hAAAA, {8'h0, holdover_word});
		holdover_active = 1'b0;
		cyc(2);
		// Average falls onto a lower word exactly; live word moves at entry so the two differ
		wr(8'h00, 8'h05);
		dco_word = 24'h000100;
		cyc(300);
		dco_word = 24'h000200;
		holdover_active = 1'b1;
		cyc(2);
		chk("holdover_word", 32'h100, {8'h0, holdover_word});
		holdover_active = 1'b0;
		cyc(2);
		give_verdict();
	end
endmodule
